/* File: carrier_timer.sv */
// Notes on behaviour
// - Eight-bit counter steps once per timer clock; wrap from FF signals time-out.
// - Every overflow reloads the counter from the reload register while enabled.
// - Green mode keeps everything running but overflow never asks for wake-up.
// - IR output enable forces PWM function even with capture selected.
// - Counter halts while the enable bit is low and counts while high.
// - Overflow sets the flag, which stays until software clears it.
// - With interrupt enable set, overflow requests the timer interrupt.
// - Reload writes land in a holding buffer, moved in at next overflow.
// - Clock source bit picks instruction clock or high-speed oscillator.
// - Instruction clock: code 0 divides by 256, down to 2 for code 7.
// - Oscillator clock: codes 0-3 divide by 1,2,4,8; codes 4-7 by 16.
// - IR output enable turns the shared pin into IR output, idling high.
// - Carrier enable low holds the pin high; high outputs the carrier.
// - Counter matching the duty compare drives the PWM output high.
// - Carrier start and each overflow drive the PWM output low.
// - Power-down forces the IR output pin high.
`timescale 1ns/1ps
`default_nettype none
module carrier_timer
  import carrier_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System clock ticks and power state.
  input  wire logic        cpu_tick,
  input  wire logic        osc_tick,
  input  wire logic        green_mode,
  input  wire logic        power_down,
  // IR receiver and pin.
  input  wire logic        ir_rx_level,
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe,
  output logic             ir_drive_pin_out,
  output logic             ir_drive_pin_oe,
  // Events to the core.
  output logic             overflow_irq,
  output logic             timeout_pulse,
  output logic             wake_request,
  output logic             capture_active,
  output logic             ir_receiver_enable
);

  // ==========================================================================
  // Register state.
  mode_cfg_t  mode;
  mode_cfg_t  next_mode;
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] reload_hold;
  logic [7:0] next_reload_hold;
  logic [7:0] reload_active;
  logic [7:0] next_reload_active;
  logic [7:0] duty;
  logic [7:0] next_duty;
  logic       overflow_flag;
  logic       next_overflow_flag;
  logic       overflow_irq_enable;
  logic       next_overflow_irq_enable;
  logic       next_rx_en;
  logic [1:0] capture_select;
  logic [1:0] next_capture_select;
  logic       carrier_start;
  logic       next_carrier_start;
  logic [31:0] next_prdata;

  logic       count_tick;
  logic       overflow;
  logic       pwm_level;
  logic       wr;
  logic       rd;
  logic       lane0;
  logic [9:0] idx;
  logic       known;

  // ==========================================================================
  // Bus decode. Writes take effect in the access phase; one-cycle answer.
  assign idx    = paddr[11:2];
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign lane0  = pstrb[0];
  assign pready = psel && penable;
  assign known  = (idx == {2'b00, IDX_RELOAD}) || (idx == {2'b00, IDX_MODE}) ||
                  (idx == {2'b00, IDX_COUNT}) || (idx == {2'b00, IDX_DUTY}) ||
                  (idx == {2'b00, IDX_STATUS});
  assign pslverr = psel && penable && !known;

  // ==========================================================================
  // Counter core.
  assign overflow = mode.enable && count_tick && count == COUNT_MAX;

  always_comb begin
    next_mode                = mode;
    next_count               = count;
    next_reload_hold         = reload_hold;
    next_reload_active       = reload_active;
    next_duty                = duty;
    next_overflow_flag       = overflow_flag;
    next_overflow_irq_enable = overflow_irq_enable;
    next_rx_en               = ir_receiver_enable;
    next_capture_select      = capture_select;
    next_carrier_start       = 1'b0;
    if (wr && lane0) begin
      if (idx == {2'b00, IDX_RELOAD}) begin
        next_reload_hold = pwdata[7:0];
      end else if (idx == {2'b00, IDX_MODE}) begin
        next_mode.enable     = pwdata[BIT_ENABLE];
        next_mode.rate       = pwdata[BIT_RATE_HI:BIT_RATE_LO];
        next_mode.clk_src    = pwdata[BIT_CLK_SRC];
        next_mode.ir_out_en  = pwdata[BIT_IR_OUT_EN];
        next_mode.carrier_en = pwdata[BIT_CARRIER_EN];
        next_carrier_start   = pwdata[BIT_CARRIER_EN] && !mode.carrier_en;
      end else if (idx == {2'b00, IDX_COUNT}) begin
        next_count = pwdata[7:0];
      end else if (idx == {2'b00, IDX_DUTY}) begin
        next_duty = pwdata[7:0];
      end else if (idx == {2'b00, IDX_STATUS}) begin
        if (!pwdata[BIT_OVF_FLAG]) begin
          next_overflow_flag = 1'b0;
        end
        next_overflow_irq_enable = pwdata[BIT_OVF_IEN];
        next_rx_en               = pwdata[BIT_RX_EN];
        next_capture_select      = pwdata[BIT_CAP_HI:BIT_CAP_LO];
      end
    end
    if (mode.enable && count_tick) begin
      if (overflow) begin
        next_count         = reload_hold;
        next_reload_active = reload_hold;
      end else begin
        next_count = 8'(count + 8'h01);
      end
    end
    if (overflow) begin
      next_overflow_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode                <= '0;
      count               <= RESET_BYTE;
      reload_hold         <= RESET_BYTE;
      reload_active       <= RESET_BYTE;
      duty                <= RESET_BYTE;
      overflow_flag       <= 1'b0;
      overflow_irq_enable <= 1'b0;
      ir_receiver_enable  <= 1'b0;
      capture_select      <= 2'b00;
      carrier_start       <= 1'b0;
      timeout_pulse       <= 1'b0;
    end else begin
      mode                <= next_mode;
      count               <= next_count;
      reload_hold         <= next_reload_hold;
      reload_active       <= next_reload_active;
      duty                <= next_duty;
      overflow_flag       <= next_overflow_flag;
      overflow_irq_enable <= next_overflow_irq_enable;
      ir_receiver_enable  <= next_rx_en;
      capture_select      <= next_capture_select;
      carrier_start       <= next_carrier_start;
      timeout_pulse       <= overflow;
    end
  end

  // ==========================================================================
  // Read data. The reload and duty registers are write-only and read zero.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (idx == {2'b00, IDX_MODE}) begin
      next_prdata[BIT_ENABLE]                = mode.enable;
      next_prdata[BIT_RATE_HI:BIT_RATE_LO]   = mode.rate;
      next_prdata[BIT_CLK_SRC]               = mode.clk_src;
      next_prdata[BIT_IR_LEVEL]              = ir_receiver_enable && ir_rx_level;
      next_prdata[BIT_IR_OUT_EN]             = mode.ir_out_en;
      next_prdata[BIT_CARRIER_EN]            = mode.carrier_en;
    end else if (idx == {2'b00, IDX_COUNT}) begin
      next_prdata[7:0] = count;
    end else if (idx == {2'b00, IDX_STATUS}) begin
      next_prdata[BIT_OVF_FLAG]          = overflow_flag;
      next_prdata[BIT_OVF_IEN]           = overflow_irq_enable;
      next_prdata[BIT_RX_EN]             = ir_receiver_enable;
      next_prdata[BIT_CAP_HI:BIT_CAP_LO] = capture_select;
    end
  end

  // Read data is registered in the setup cycle so it is stable at the access edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // Sub-blocks.
  timer_prescaler u_prescaler (
    .clk        (clk),
    .rst        (rst),
    .cpu_tick   (cpu_tick),
    .osc_tick   (osc_tick),
    .enable     (mode.enable),
    .clk_src    (mode.clk_src),
    .rate       (mode.rate),
    .count_tick (count_tick)
  );

  carrier_pwm u_pwm (
    .clk           (clk),
    .rst           (rst),
    .carrier_start (carrier_start),
    .overflow      (overflow),
    .count_tick    (count_tick),
    .count         (count),
    .duty          (duty),
    .ir_out_en     (mode.ir_out_en),
    .carrier_en    (mode.carrier_en),
    .power_down    (power_down),
    .pwm_level     (pwm_level)
  );

  // ==========================================================================
  // Outputs. The core reads the flag and enable to vector to the handler.
  assign overflow_irq   = overflow_flag && overflow_irq_enable;
  // This timer never wakes the system, in green mode or otherwise.
  assign wake_request   = 1'b0;
  assign capture_active = (capture_select != 2'b00) && !mode.ir_out_en;
  // The pin follows the live gpio_out and gpio_oe inputs when IR output is off.
  assign ir_drive_pin_out = mode.ir_out_en ? pwm_level : gpio_out;
  assign ir_drive_pin_oe  = mode.ir_out_en ? 1'b1 : gpio_oe;

  logic unused;
  assign unused = green_mode ^ ^pwdata[31:8] ^ ^pstrb[3:1] ^ ^reload_active;

endmodule : carrier_timer
`default_nettype wire

/* File: carrier_timer_pkg.sv */
package carrier_timer_pkg;

  // ==========================================================================
  // Register word addresses (each register takes one aligned word).
  // Some printed offsets are not multiples of four, so each offset is an index.
  localparam logic [7:0] IDX_RELOAD  = 8'hCD;
  localparam logic [7:0] IDX_MODE    = 8'hDA;
  localparam logic [7:0] IDX_COUNT   = 8'hDB;
  localparam logic [7:0] IDX_DUTY    = 8'hE8;
  localparam logic [7:0] IDX_STATUS  = 8'hF0;

  // ==========================================================================
  // Mode register field positions.
  localparam int BIT_ENABLE     = 7;
  localparam int BIT_RATE_HI    = 6;
  localparam int BIT_RATE_LO    = 4;
  localparam int BIT_CLK_SRC    = 3;
  localparam int BIT_IR_LEVEL   = 2;
  localparam int BIT_IR_OUT_EN  = 1;
  localparam int BIT_CARRIER_EN = 0;

  // Status/control register field positions.
  localparam int BIT_OVF_FLAG   = 0;
  localparam int BIT_OVF_IEN    = 1;
  localparam int BIT_RX_EN      = 2;
  localparam int BIT_CAP_LO     = 3;
  localparam int BIT_CAP_HI     = 4;

  // ==========================================================================
  // Reset values and counter limits.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hFF;

  // ==========================================================================
  // Mode register fields, fed to the prescaler and carrier, travel together.
  typedef struct packed {
    logic       enable;
    logic [2:0] rate;
    logic       clk_src;
    logic       ir_out_en;
    logic       carrier_en;
  } mode_cfg_t;

endpackage : carrier_timer_pkg

/* File: timer_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
  import carrier_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Source ticks and selection.
  input  wire logic cpu_tick,
  input  wire logic osc_tick,
  input  wire logic enable,
  input  wire logic clk_src,
  input  wire logic [2:0] rate,
  // Prescaled timer clock.
  output logic      count_tick
);

  logic       src_tick;
  logic [7:0] div;
  logic [7:0] next_div;
  logic [7:0] limit;

  // Divisor minus one for the selected source.
  function automatic logic [7:0] div_limit(input logic src, input logic [2:0] r);
    if (src) begin
      div_limit = r[2] ? 8'h0F : 8'((8'h01 << r[1:0]) - 8'h01);
    end else begin
      div_limit = 8'((9'h100 >> r) - 9'h001);
    end
  endfunction : div_limit

  assign src_tick = clk_src ? osc_tick : cpu_tick;
  assign limit    = div_limit(clk_src, rate);

  always_comb begin
    next_div   = div;
    count_tick = 1'b0;
    if (!enable) begin
      next_div = RESET_BYTE;
    end else if (src_tick) begin
      if (div >= limit) begin
        next_div   = RESET_BYTE;
        count_tick = 1'b1;
      end else begin
        next_div = 8'(div + 8'h01);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div <= RESET_BYTE;
    end else begin
      div <= next_div;
    end
  end

endmodule : timer_prescaler
`default_nettype wire

/* File: carrier_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
module carrier_pwm
  import carrier_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Timer state.
  input  wire logic       carrier_start,
  input  wire logic       overflow,
  input  wire logic       count_tick,
  input  wire logic [7:0] count,
  input  wire logic [7:0] duty,
  input  wire logic       ir_out_en,
  input  wire logic       carrier_en,
  input  wire logic       power_down,
  // Carrier level.
  output logic            pwm_level
);

  logic wave;
  logic next_wave;

  always_comb begin
    next_wave = wave;
    if (carrier_start || overflow) begin
      next_wave = 1'b0;
    end else if (count_tick && 8'(count + 8'h01) == duty) begin
      // Match on the value being stepped into, so the low part lasts duty minus reload ticks.
      next_wave = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wave      <= 1'b1;
      pwm_level <= 1'b1;
    end else begin
      wave <= next_wave;
      // Idle high unless the carrier runs; power-down always forces high.
      pwm_level <= (power_down || !ir_out_en || !carrier_en) ? 1'b1 : next_wave;
    end
  end

endmodule : carrier_pwm
`default_nettype wire

/* File: carrier_timer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module carrier_timer_assertions (
  // Bus.
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Pin and events.
  input wire logic        power_down,
  input wire logic        gpio_out,
  input wire logic        ir_drive_pin_out,
  input wire logic        ir_drive_pin_oe,
  input wire logic        overflow_irq,
  input wire logic        timeout_pulse,
  input wire logic        wake_request
);
  // ====
  // Shadow bits rebuilt from completed writes, so no internal state is needed.
  logic ir_on, cr_on, ien;
  always_ff @(posedge clk) begin
    if (rst) begin
      {ir_on, cr_on, ien} <= 3'b000;
    end else if (psel && penable && pwrite && paddr == 12'h368) begin
      {ir_on, cr_on} <= pwdata[1:0];
    end else if (psel && penable && pwrite && paddr == 12'h3C0) begin
      ien <= pwdata[1];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // Checks.
  a_never_wake: assert property (!wake_request)
    else $error("wake request raised");
  a_pulse_single: assert property (timeout_pulse |=> !timeout_pulse)
    else $error("time-out pulse too long");
  a_irq_follows: assert property (ien && $past(ien) && timeout_pulse |-> overflow_irq)
    else $error("overflow without interrupt");
  a_irq_gated: assert property (!ien && !$past(ien) |-> !overflow_irq)
    else $error("interrupt while disabled");
  a_pd_high: assert property (ir_on && power_down && $past(ir_on && power_down)
    |-> ir_drive_pin_out)
    else $error("pin low in power-down");
  a_idle_high: assert property (ir_on && !cr_on && $past(ir_on && !cr_on)
    |-> ir_drive_pin_out)
    else $error("pin low with carrier off");
  a_ir_drives: assert property (ir_on && $past(ir_on) |-> ir_drive_pin_oe)
    else $error("IR pin not driven");
  a_gpio_pass: assert property (!ir_on && !$past(ir_on) && $stable(gpio_out)
    |-> ir_drive_pin_out == gpio_out)
    else $error("GPIO value not on pin");
  c_irq: cover property (timeout_pulse && ien);
  c_flash: cover property (ir_on && cr_on && $fell(ir_drive_pin_out));
  c_pd: cover property (ir_on && cr_on && power_down);
endmodule : carrier_timer_assertions
`default_nettype wire

/* File: ir_emitter_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ir_emitter_model (
  // Clock and clear.
  input  wire logic       clk,
  input  wire logic       clr,
  // Pin and measured flash.
  input  wire logic       pin_out,
  input  wire logic       pin_oe,
  output logic      [9:0] low_len,
  output logic      [9:0] period
);
  // ====
  // The LED sinks current only while the pin drives low; a released pin is dark.
  logic       lit, lit_q;
  logic [9:0] lo_c, per_c;
  assign lit = pin_oe && !pin_out;
  always_ff @(posedge clk) begin
    if (clr) begin
      {lit_q, low_len, period, lo_c, per_c} <= '0;
    end else begin
      lit_q <= lit;
      per_c <= (lit && !lit_q) ? 10'h001 : per_c + 10'h001;
      lo_c  <= (lit && !lit_q) ? 10'h001 : lo_c + 10'(lit);
      if (lit && !lit_q) begin
        low_len <= lo_c;
        period  <= per_c;
      end
    end
  end
endmodule : ir_emitter_model
`default_nettype wire

/* File: carrier_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module carrier_timer_tb
  import carrier_timer_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, cpu_tick, osc_tick, re, em_clr;
  logic green_mode, power_down, ir_rx_level, gpio_out, gpio_oe, ir_drive_pin_out;
  logic ir_drive_pin_oe, overflow_irq, timeout_pulse, wake_request, capture_active;
  logic        ir_receiver_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [9:0]  low_len, period;
  logic [7:0]  rq, r1, r2, v;
  int          err_count, comparisons, n, seed = 52060;
  int          cyc, mark;
  logic [7:0]  reg_idx [5] = '{IDX_RELOAD, IDX_MODE, IDX_COUNT, IDX_DUTY, IDX_STATUS};
  carrier_timer i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cpu_tick, .osc_tick, .green_mode, .power_down,
    .ir_rx_level, .gpio_out, .gpio_oe, .ir_drive_pin_out, .ir_drive_pin_oe,
    .overflow_irq, .timeout_pulse, .wake_request, .capture_active, .ir_receiver_enable);
  ir_emitter_model i_led (.clk, .clr(em_clr), .pin_out(ir_drive_pin_out),
    .pin_oe(ir_drive_pin_oe), .low_len, .period);
  // ====
  // Clock and free-running stimulus.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cpu_tick <= cyc[0];
    {gpio_out, gpio_oe} <= 2'($random(seed));
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic stop();
    err_count++;
    $display("mismatch t=%0t wait ran out", $time);
    tally_and_finish();
  endtask : stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; waits for pready rather than assuming zero wait states.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) stop();
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Period is taken pulse to pulse from a free cycle count, so bus traffic between waits
  // does not shorten it.
  task automatic gap();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (timeout_pulse !== 1'b1 && k < 3000);
    if (timeout_pulse !== 1'b1) stop();
    n = cyc - mark;
    mark = cyc;
  endtask : gap
  task automatic flash(input logic [9:0] lo, input logic [9:0] per);
    em_clr <= 1'b1;
    @(posedge clk);
    em_clr <= 1'b0;
    repeat (3) gap();
    check(32'(low_len), 32'(lo));
    check(32'(period), 32'(per));
  endtask : flash
  // ====
  // Main sequence.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, green_mode, power_down} = '0;
    {ir_rx_level, rst, em_clr, osc_tick, pstrb} = 8'h7F;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    em_clr <= 1'b0;
    foreach (reg_idx[i]) begin
      apb(1'b0, reg_idx[i], 8'h00);
      check(rq, RESET_BYTE);
      check(re, 1'b0);
    end
    apb(1'b1, IDX_DUTY, 8'h5A);
    apb(1'b0, IDX_DUTY, 8'h00);
    check(rq, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    check(re, 1'b1);
    $display("test registers done");
    // Two ticks per overflow; cpu ticks arrive every second clock.
    for (int s = 0; s < 2; s++) for (int r = 0; r < 8; r++) begin
      apb(1'b1, IDX_MODE, {1'b0, r[2:0], s[0], 3'b000});
      apb(1'b1, IDX_COUNT, 8'hFE);
      apb(1'b1, IDX_RELOAD, 8'hFE);
      apb(1'b1, IDX_MODE, {1'b1, r[2:0], s[0], 3'b000});
      gap();
      gap();
      check(n, s ? 2 * ((r < 4) ? 1 << r : 16) : 4 * (256 >> r));
    end
    $display("test prescale done");
    green_mode <= 1'b1;
    r1 = 8'h80 + 8'($random(seed) & 32'h3F);
    r2 = 8'hC0 + 8'($random(seed) & 32'h1F);
    apb(1'b1, IDX_MODE, 8'h08);
    apb(1'b1, IDX_COUNT, r1);
    apb(1'b1, IDX_RELOAD, r1);
    apb(1'b1, IDX_MODE, 8'h88);
    gap();
    apb(1'b1, IDX_RELOAD, r2);
    gap();
    check(n, 256 - r1);
    gap();
    check(n, 256 - r2);
    $display("test reload done");
    apb(1'b1, IDX_MODE, 8'h08);
    apb(1'b0, IDX_COUNT, 8'h00);
    v = rq;
    repeat (40) @(posedge clk);
    apb(1'b0, IDX_COUNT, 8'h00);
    check(rq, v);
    apb(1'b1, IDX_STATUS, 8'h03);
    check(overflow_irq, 1'b1);
    apb(1'b1, IDX_STATUS, 8'h02);
    check(overflow_irq, 1'b0);
    $display("test flag done");
    for (int l = 0; l < 2; l++) begin
      ir_rx_level <= l[0];
      apb(1'b1, IDX_STATUS, 8'h04);
      check(ir_receiver_enable, 1'b1);
      apb(1'b0, IDX_MODE, 8'h00);
      check(rq[2], l[0]);
    end
    $display("test receiver done");
    r2 = r1 + 8'h01 + 8'($random(seed) & 32'h3F);
    apb(1'b1, IDX_STATUS, 8'h1A);
    apb(1'b1, IDX_COUNT, r1);
    apb(1'b1, IDX_RELOAD, r1);
    apb(1'b1, IDX_DUTY, r2);
    apb(1'b1, IDX_MODE, 8'h0A);
    apb(1'b1, IDX_MODE, 8'h8B);
    check(capture_active, 1'b0);
    flash(10'(r2 - r1), 10'(256 - r1));
    apb(1'b1, IDX_MODE, 8'h8A);
    flash(10'h000, 10'h000);
    apb(1'b1, IDX_MODE, 8'h8B);
    power_down <= 1'b1;
    flash(10'h000, 10'h000);
    power_down <= 1'b0;
    apb(1'b1, IDX_MODE, 8'h88);
    check(capture_active, 1'b1);
    $display("test carrier done");
    tally_and_finish();
  end
endmodule : carrier_timer_tb
bind carrier_timer carrier_timer_assertions i_chk (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .power_down, .gpio_out, .ir_drive_pin_out, .ir_drive_pin_oe,
  .overflow_irq, .timeout_pulse, .wake_request);
`default_nettype wire
